// >>> rtl/eit_pkg.sv
// Package with register map, field positions and reset values of the external interrupt flag block.
package eit_pkg;
  localparam logic [3:0] ADDR_TIMER_AND_EXT_IRQ_CONTROL  = 4'h0;
  localparam logic [3:0] ADDR_PINCFG                     = 4'h4;
  localparam logic [3:0] ADDR_STATUS                     = 4'h8;
  localparam logic [3:0] ADDR_MASK                       = 4'hC;
  localparam int         BIT_EXT_IRQ0_TRIGGER_TYPE       = 0;
  localparam int         BIT_EXT_IRQ0_PENDING_FLAG       = 1;
  localparam int         BIT_EXT_IRQ1_TRIGGER_TYPE       = 2;
  localparam int         BIT_EXT_IRQ1_PENDING_FLAG       = 3;
  localparam int         BIT_POL0                        = 0;
  localparam int         BIT_POL1                        = 1;
  localparam logic [7:0] TIMER_AND_EXT_IRQ_CONTROL_RESET = 8'h00;
  localparam logic [1:0] POL_RESET                       = 2'b00;
  localparam logic [1:0] MASK_RESET                      = 2'b00;
  localparam logic [1:0] RESP_OKAY                       = 2'b00;
  localparam logic [1:0] RESP_SLVERR                     = 2'b10;
  localparam int         NUM_IRQ                         = 2;
  typedef enum logic {EIT_LEVEL, EIT_EDGE} eit_trig_e;
endpackage

// >>> rtl/eit_flag_if.sv
// Interface carrying per-input flag control between the top and the detector.
`timescale 1ns/1ps
`default_nettype none
interface eit_flag_if;
  logic [1:0] pin;
  logic [1:0] pol;
  logic [1:0] trig;
  logic [1:0] sw_clr;
  logic [1:0] sw_set;
  logic [1:0] vec_ack;
  logic [1:0] flag;
  logic [1:0] event_p;
  modport ctl (output pin, pol, trig, sw_clr, sw_set, vec_ack, input flag, event_p);
  modport det (input pin, pol, trig, sw_clr, sw_set, vec_ack, output flag, event_p);
endinterface
`default_nettype wire

// >>> rtl/eit_detect.sv
// Per-input edge/level detector and pending flag.
`timescale 1ns/1ps
`default_nettype none
module eit_detect
  import eit_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  eit_flag_if.det  fi
);
  logic [1:0] prev_reg;
  logic [1:0] prev_next;
  logic [1:0] flag_reg;
  logic [1:0] flag_next;
  logic [1:0] act;
  logic [1:0] det;

  always_comb begin
    for (int i = 0; i < NUM_IRQ; i++) begin
      act[i] = fi.pin[i] ~^ fi.pol[i];
      // Edge mode fires on the inactive-to-active transition, level mode while active.
      det[i] = (fi.trig[i] == EIT_EDGE) ? (act[i] & ~prev_reg[i]) : act[i];
      flag_next[i] = flag_reg[i];
      if (fi.sw_clr[i])
        flag_next[i] = 1'b0;
      if (fi.vec_ack[i] && fi.trig[i] == EIT_EDGE)
        flag_next[i] = 1'b0;
      if (fi.sw_set[i])
        flag_next[i] = 1'b1;
      if (det[i])
        flag_next[i] = 1'b1;
    end
    prev_next = act;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prev_reg <= 2'b00;
      flag_reg <= 2'b00;
    end else begin
      prev_reg <= prev_next;
      flag_reg <= flag_next;
    end
  end

  assign fi.flag    = flag_reg;
  assign fi.event_p = det & ~flag_reg;

  a_level_holds_flag: assert property (@(posedge ref_clk) disable iff (rst)
    (fi.trig[1] == EIT_LEVEL && act[1]) |=> flag_reg[1])
    else $error("level active but flag 1 clear");
  a_edge_sets_flag: assert property (@(posedge ref_clk) disable iff (rst)
    (fi.trig[1] == EIT_EDGE && act[1] && !prev_reg[1]) |=> flag_reg[1])
    else $error("edge missed on input 1");
  a_vector_clears: assert property (@(posedge ref_clk) disable iff (rst)
    (fi.vec_ack[1] && fi.trig[1] == EIT_EDGE && !det[1] && !fi.sw_set[1]) |=> !flag_reg[1])
    else $error("vector did not clear flag 1");
  a_irq0_level: assert property (@(posedge ref_clk) disable iff (rst)
    (fi.trig[0] == EIT_LEVEL && (fi.pin[0] ~^ fi.pol[0])) |=> flag_reg[0])
    else $error("level active but flag 0 clear");
endmodule
`default_nettype wire

// >>> rtl/eit_top.sv
// Top of the external interrupt flag and trigger block with its AXI4-Lite register slave.
//
// What this block does
// - Hardware sets input 1 flag on chosen condition.
// - Software clears flag; vectoring clears in edge.
// - Level mode keeps flag set while active.
// - Trigger-type bit picks edge or level.
// - Polarity bit sets input active level.
`timescale 1ns/1ps
`default_nettype none
module eit_top
  import eit_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       ext_irq0_input,
  input  wire logic       ext_irq1_input,
  input  wire logic       vec_ack0,
  input  wire logic       vec_ack1,
  output logic            ext_irq0_pending_flag,
  output logic            ext_irq1_pending_flag,
  output logic            irq,
  input  wire logic [3:0] s_axi_awaddr,
  input  wire logic       s_axi_awvalid,
  output logic            s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0] s_axi_wstrb,
  input  wire logic       s_axi_wvalid,
  output logic            s_axi_wready,
  output logic [1:0]      s_axi_bresp,
  output logic            s_axi_bvalid,
  input  wire logic       s_axi_bready,
  input  wire logic [3:0] s_axi_araddr,
  input  wire logic       s_axi_arvalid,
  output logic            s_axi_arready,
  output logic [31:0]     s_axi_rdata,
  output logic [1:0]      s_axi_rresp,
  output logic            s_axi_rvalid,
  input  wire logic       s_axi_rready
);
  eit_flag_if fi ();

  // ********************************
  // Register state.
  // ********************************
  logic [1:0]  trig_reg, trig_next;
  logic [1:0]  pol_reg, pol_next;
  logic [1:0]  mask_reg, mask_next;
  logic [1:0]  stat_reg, stat_next;
  logic        irq_reg, irq_next;
  logic [1:0]  flag_o_reg, flag_o_next;
  logic        aw_got_reg, aw_got_next;
  logic        w_got_reg, w_got_next;
  logic [3:0]  awaddr_reg, awaddr_next;
  logic [7:0]  wdata_reg, wdata_next;
  logic        wstrb_reg, wstrb_next;
  logic        bvalid_reg, bvalid_next;
  logic [1:0]  bresp_reg, bresp_next;
  logic        rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0]  rresp_reg, rresp_next;
  logic        do_wr, do_rd;
  logic [3:0]  wa;
  logic [7:0]  wd;
  logic [7:0]  timer_and_ext_irq_control;
  logic        awready_reg, awready_next;
  logic        wready_reg, wready_next;
  logic        arready_reg, arready_next;

  assign fi.pin     = {ext_irq1_input, ext_irq0_input};
  assign fi.pol     = pol_reg;
  assign fi.trig    = trig_reg;
  assign fi.vec_ack = {vec_ack1, vec_ack0};

  eit_detect u_det (
    .ref_clk (ref_clk),
    .rst     (rst),
    .fi      (fi)
  );

  assign timer_and_ext_irq_control = {4'h0, fi.flag[1], trig_reg[1], fi.flag[0], trig_reg[0]};

  // ********************************
  // Bus decode and next state.
  // ********************************
  always_comb begin
    aw_got_next = aw_got_reg;
    w_got_next  = w_got_reg;
    awaddr_next = awaddr_reg;
    wdata_next  = wdata_reg;
    wstrb_next  = wstrb_reg;
    if (s_axi_awvalid && !aw_got_reg) begin
      aw_got_next = 1'b1;
      awaddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_got_reg) begin
      w_got_next = 1'b1;
      wdata_next = s_axi_wdata[7:0];
      wstrb_next = s_axi_wstrb[0];
    end
    do_wr = aw_got_reg && w_got_reg && !bvalid_reg;
    wa    = awaddr_reg;
    wd    = wdata_reg;
    if (do_wr) begin
      aw_got_next = 1'b0;
      w_got_next  = 1'b0;
    end
    trig_next    = trig_reg;
    pol_next     = pol_reg;
    mask_next    = mask_reg;
    fi.sw_clr    = 2'b00;
    fi.sw_set    = 2'b00;
    bvalid_next  = bvalid_reg && !s_axi_bready;
    bresp_next   = bresp_reg;
    if (do_wr) begin
      bvalid_next = 1'b1;
      bresp_next  = RESP_OKAY;
      if (wstrb_reg) begin
        unique case ({wa[3:2], 2'b00})
          ADDR_TIMER_AND_EXT_IRQ_CONTROL: begin
            trig_next = {wd[BIT_EXT_IRQ1_TRIGGER_TYPE], wd[BIT_EXT_IRQ0_TRIGGER_TYPE]};
            // Writing zero to a pending bit clears it, writing one sets it.
            fi.sw_clr = {~wd[BIT_EXT_IRQ1_PENDING_FLAG], ~wd[BIT_EXT_IRQ0_PENDING_FLAG]};
            fi.sw_set = {wd[BIT_EXT_IRQ1_PENDING_FLAG], wd[BIT_EXT_IRQ0_PENDING_FLAG]} & ~fi.flag;
          end
          ADDR_PINCFG: pol_next  = {wd[BIT_POL1], wd[BIT_POL0]};
          ADDR_MASK:   mask_next = wd[1:0];
          default:     bresp_next = (({wa[3:2], 2'b00}) == ADDR_STATUS) ? RESP_OKAY : RESP_SLVERR;
        endcase
      end
    end
    do_rd       = s_axi_arvalid && !rvalid_reg;
    rvalid_next = rvalid_reg && !s_axi_rready;
    rdata_next  = rdata_reg;
    rresp_next  = rresp_reg;
    stat_next   = stat_reg | fi.event_p;
    if (do_rd) begin
      rvalid_next = 1'b1;
      rresp_next  = RESP_OKAY;
      unique case ({s_axi_araddr[3:2], 2'b00})
        ADDR_TIMER_AND_EXT_IRQ_CONTROL: rdata_next = {24'h00_0000, timer_and_ext_irq_control};
        ADDR_PINCFG: rdata_next = {30'h0000_0000, pol_reg};
        ADDR_STATUS: begin
          rdata_next = {30'h0000_0000, stat_reg};
          // Reading clears the sticky bits, but an event this cycle survives.
          stat_next  = fi.event_p;
        end
        ADDR_MASK:   rdata_next = {30'h0000_0000, mask_reg};
        default: begin
          rdata_next = 32'h0000_0000;
          rresp_next = RESP_SLVERR;
        end
      endcase
    end
    irq_next    = |(stat_next & mask_next);
    flag_o_next = fi.flag;
    // Ready outputs are registered copies of the channel state they report.
    awready_next = !aw_got_next;
    wready_next  = !w_got_next;
    arready_next = !rvalid_next;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      trig_reg   <= {TIMER_AND_EXT_IRQ_CONTROL_RESET[BIT_EXT_IRQ1_TRIGGER_TYPE],
                     TIMER_AND_EXT_IRQ_CONTROL_RESET[BIT_EXT_IRQ0_TRIGGER_TYPE]};
      pol_reg    <= POL_RESET;
      mask_reg   <= MASK_RESET;
      stat_reg   <= 2'b00;
      irq_reg    <= 1'b0;
      flag_o_reg <= 2'b00;
      aw_got_reg <= 1'b0;
      w_got_reg  <= 1'b0;
      awaddr_reg <= 4'h0;
      wdata_reg  <= 8'h00;
      wstrb_reg  <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= RESP_OKAY;
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
      arready_reg <= 1'b1;
    end else begin
      trig_reg   <= trig_next;
      pol_reg    <= pol_next;
      mask_reg   <= mask_next;
      stat_reg   <= stat_next;
      irq_reg    <= irq_next;
      flag_o_reg <= flag_o_next;
      aw_got_reg <= aw_got_next;
      w_got_reg  <= w_got_next;
      awaddr_reg <= awaddr_next;
      wdata_reg  <= wdata_next;
      wstrb_reg  <= wstrb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg  <= bresp_next;
      rvalid_reg <= rvalid_next;
      rdata_reg  <= rdata_next;
      rresp_reg  <= rresp_next;
      awready_reg <= awready_next;
      wready_reg  <= wready_next;
      arready_reg <= arready_next;
    end
  end

  // ********************************
  // Outputs.
  // ********************************
  assign ext_irq0_pending_flag = flag_o_reg[0];
  assign ext_irq1_pending_flag = flag_o_reg[1];
  assign irq                   = irq_reg;
  assign s_axi_awready         = awready_reg;
  assign s_axi_wready          = wready_reg;
  assign s_axi_bvalid          = bvalid_reg;
  assign s_axi_bresp           = bresp_reg;
  assign s_axi_arready         = arready_reg;
  assign s_axi_rvalid          = rvalid_reg;
  assign s_axi_rdata           = rdata_reg;
  assign s_axi_rresp           = rresp_reg;

  a_trig_write: assert property (@(posedge ref_clk) disable iff (rst)
    (do_wr && wstrb_reg && wa == ADDR_TIMER_AND_EXT_IRQ_CONTROL)
    |=> trig_reg == {$past(wd[BIT_EXT_IRQ1_TRIGGER_TYPE]), $past(wd[BIT_EXT_IRQ0_TRIGGER_TYPE])})
    else $error("trigger type not stored");
  a_pol_write: assert property (@(posedge ref_clk) disable iff (rst)
    (do_wr && wstrb_reg && wa == ADDR_PINCFG) |=> pol_reg[1] == $past(wd[BIT_POL1]))
    else $error("polarity not stored");
  a_sw_clear: assert property (@(posedge ref_clk) disable iff (rst)
    (fi.sw_clr[1] && !(fi.trig[1] == EIT_LEVEL && (ext_irq1_input ~^ pol_reg[1]))
     && !(ext_irq1_input ~^ pol_reg[1])) |=> ##1 !ext_irq1_pending_flag)
    else $error("software clear of flag 1 failed");
  a_flag_output: assert property (@(posedge ref_clk) disable iff (rst)
    fi.flag[1] |=> ext_irq1_pending_flag)
    else $error("flag 1 not shown at port");
endmodule
`default_nettype wire

// >>> test/eit_pin_model.sv
// Partner model of the interrupt pins and the CPU vectoring handshake.
`timescale 1ns/1ps
`default_nettype none
module eit_pin_model (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic [1:0] pin_lvl,
  input  wire logic [1:0] ack_en,
  input  wire logic [1:0] flag,
  output logic [1:0]      pin,
  output var logic [1:0]  vec_ack
);
  assign pin = pin_lvl;
  // The CPU vectors to a pending request, with an idle cycle after each acknowledge.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      vec_ack <= 2'b00;
    end else begin
      vec_ack <= ack_en & flag & ~vec_ack;
    end
  end
endmodule
`default_nettype wire

// >>> test/eit_top_tb.sv
// Self-checking testbench of the external interrupt flag block.
`timescale 1ns/1ps
`default_nettype none
module eit_top_tb;
  import eit_pkg::*;
  logic ref_clk = 1'b0, rst = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0000_0000, rdata, m_tmp;
  logic [1:0] pins = 2'b11, ack_en = 2'b00, pin, vack, flg, bresp, rresp;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [31:0] rq[$], mq[$];
  logic [1:0] bq[$];
  int n_mismatch = 0, checks_done = 0, cyc = 0;
  always #4 ref_clk = ~ref_clk;
  eit_pin_model u_pin (.ref_clk(ref_clk), .rst(rst), .pin_lvl(pins), .ack_en(ack_en), .flag(flg), .pin(pin),
    .vec_ack(vack));
  eit_top u_dut (.ref_clk(ref_clk), .rst(rst), .ext_irq0_input(pin[0]), .ext_irq1_input(pin[1]),
    .vec_ack0(vack[0]), .vec_ack1(vack[1]), .ext_irq0_pending_flag(flg[0]), .ext_irq1_pending_flag(flg[1]),
    .irq(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  task automatic chk_data(input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] rdata expected %h seen %h", e, g);
    end
  endtask
  task automatic chk_resp(input string nm, input logic [1:0] e, input logic [1:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_pin(input string nm, input logic e, input logic g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %b seen %b", nm, e, g);
    end
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task wt(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    bit ad, wd;
    bq.push_back(RESP_OKAY);
    ad = 0;
    wd = 0;
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge ref_clk);
      if (awready && !ad) begin ad = 1; awvalid <= 1'b0; end
      if (wready && !wd) begin wd = 1; wvalid <= 1'b0; end
    end
    while (!bvalid) @(posedge ref_clk);
    bready <= 1'b0;
    @(posedge ref_clk);
  endtask
  task rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    rq.push_back(e);
    mq.push_back(m);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do @(posedge ref_clk); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge ref_clk);
    rready <= 1'b0;
    @(posedge ref_clk);
  endtask
  // ************************************************************
  // Read results are checked against the oldest queued note.
  // ************************************************************
  always @(posedge ref_clk) begin
    if (rvalid && rready) begin
      m_tmp = mq.pop_front();
      chk_data(rq.pop_front(), rdata & m_tmp);
      chk_resp("rresp", RESP_OKAY, rresp);
    end
    if (bvalid && bready) chk_resp("bresp", bq.pop_front(), bresp);
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_mismatch++;
      final_report();
    end
  end
  initial begin
    logic idx, pl, tg;
    logic [31:0] tc, pend;
    void'($urandom(48620));
    wt(16);
    rst <= 1'b0;
    @(posedge ref_clk);
    rd(ADDR_TIMER_AND_EXT_IRQ_CONTROL, 32'hFFFF_FFFF, {24'h00_0000, TIMER_AND_EXT_IRQ_CONTROL_RESET});
    rd(ADDR_PINCFG, 32'hFFFF_FFFF, {30'h0000_0000, POL_RESET});
    rd(ADDR_MASK, 32'hFFFF_FFFF, {30'h0000_0000, MASK_RESET});
    // A write with its low byte strobe clear must leave the register as it was.
    wstrb <= 4'h0;
    wr(ADDR_MASK, 32'h0000_0003);
    wstrb <= 4'hF;
    rd(ADDR_MASK, 32'hFFFF_FFFF, {30'h0000_0000, MASK_RESET});
    $display("test reset and strobe done");
    for (int k = 0; k < 8; k++) begin
      {tg, pl, idx} = 3'(k);
      pend = 32'(1) << (idx ? BIT_EXT_IRQ1_PENDING_FLAG : BIT_EXT_IRQ0_PENDING_FLAG);
      tc = ($urandom() & 32'hFFFF_FF00) | (tg ? 32'h0000_0005 : 32'h0000_0000);
      pins <= {2{~pl}};
      wr(ADDR_PINCFG, {30'h0000_0000, pl, pl});
      wr(ADDR_TIMER_AND_EXT_IRQ_CONTROL, tc);
      wt(6);
      wr(ADDR_TIMER_AND_EXT_IRQ_CONTROL, tc);
      rd(ADDR_STATUS, 32'h0000_0000, 32'h0000_0000);
      rd(ADDR_STATUS, 32'h0000_0003, 32'h0000_0000);
      wr(ADDR_MASK, 32'(1) << idx);
      wt(4);
      chk_pin("flag", 1'b0, flg[idx]);
      chk_pin("irq", 1'b0, irq);
      pins[idx] <= pl;
      wt($urandom_range(3, 1));
      if (tg) pins[idx] <= ~pl;
      wt(6);
      chk_pin("flag", 1'b1, flg[idx]);
      chk_pin("irq", 1'b1, irq);
      rd(ADDR_TIMER_AND_EXT_IRQ_CONTROL, pend, pend);
      wr(ADDR_TIMER_AND_EXT_IRQ_CONTROL, tc);
      wt(3);
      chk_pin("flag", ~tg, flg[idx]);
      pins[idx] <= ~pl;
      wt(6);
      wr(ADDR_TIMER_AND_EXT_IRQ_CONTROL, tc);
      wt(3);
      chk_pin("flag", 1'b0, flg[idx]);
      if (tg) begin
        ack_en[idx] <= 1'b1;
        pins[idx] <= pl;
        wt(2);
        pins[idx] <= ~pl;
        wt(10);
        chk_pin("flag", 1'b0, flg[idx]);
        ack_en <= 2'b00;
      end
      rd(ADDR_STATUS, 32'h0000_0003, 32'(1) << idx);
      wt(4);
      chk_pin("irq", 1'b0, irq);
      $display("test %0d done: input %0d polarity %0d edge %0d", k, idx, pl, tg);
    end
    final_report();
  end
endmodule
`default_nettype wire
